/* core/aar_regs.sv */
// AHB-Lite register slice: advertisement, partner base page and expansion
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps

// Overview of operation
// - Advertisement writes reach the negotiation engine only when restart is set
// - Bits 8:5 hold the technology abilities and are software writable
// - Bit 5 advertises 10BASE-T half duplex
// - Advertisement is sixteen bits and resets to 0x01E1
// - Advertisement selector bits 4:0 read 0x01 and ignore writes
// - Partner base page is captured from the link, read only, resets zero
// - Partner selector is decoded into 802.3, ISLAN, 802.5, 1394 or reserved
// - Expansion is read only, resets zero, reports both ends' capabilities
module aar_regs
    import aar_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_reset_n,
    input  wire logic          i_hsel,
    input  wire logic [31:0]   i_haddr,
    input  wire logic [1:0]    i_htrans,
    input  wire logic          i_hwrite,
    input  wire logic [2:0]    i_hsize,
    input  wire logic [31:0]   i_hwdata,
    input  wire logic          i_hready,
    output logic               o_hreadyout,
    output logic               o_hresp,
    output logic [31:0]        o_hrdata,
    input  wire aar_lp_page_t  i_lp_page,
    input  wire aar_an_done_t  i_an_done,
    output logic [15:0]        o_adv_active,
    output logic               o_restart,
    output aar_selector_t      o_lp_selector
);

    logic        rf_reg;
    logic [3:0]  tech_reg;
    logic [15:0] active_reg;
    logic        restart_reg;
    logic [15:0] lp_reg;
    logic [15:0] exp_reg;
    logic        dp_write_reg;
    logic [7:0]  dp_index_reg;
    logic        dp_valid_reg;

    // Address phase capture; the slave never stalls, so hreadyout is high
    wire         addr_take = i_hsel & i_hready & i_htrans[1];
    wire  [7:0]  addr_index = i_haddr[9:2];
    // Only whole aligned words are decoded; any other size is treated as unmapped
    wire         addr_word = (i_haddr[31:10] == 22'h000000) & (i_haddr[1:0] == 2'b00)
                             & (i_hsize == 3'h2);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_index_reg <= 8'h00;
        end else if (i_hready) begin
            dp_valid_reg <= addr_take & addr_word;
            dp_write_reg <= i_hwrite;
            dp_index_reg <= addr_index;
        end
    end

    wire wr_adv  = dp_valid_reg & dp_write_reg & (dp_index_reg == IDX_ADVERTISEMENT);
    wire wr_ctrl = dp_valid_reg & dp_write_reg & (dp_index_reg == IDX_BASIC_CONTROL);
    wire restart_next = wr_ctrl & i_hwdata[RESTART_BIT];

    // Stored advertisement view; selector and next page are constants
    wire [15:0] adv_view = {1'b0, 1'b0, rf_reg, 4'h0, tech_reg, SEL_IEEE_8023};

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rf_reg   <= 1'b0;
            tech_reg <= TECH_RESET;
        end else if (wr_adv) begin
            rf_reg   <= i_hwdata[REMOTE_FAULT_BIT];
            tech_reg <= i_hwdata[TECH_MSB:TECH_LSB];
        end
    end

    // The engine sees a frozen copy so a half-finished edit never leaks mid-negotiation
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            restart_reg <= 1'b0;
            active_reg  <= ADV_RESET;
        end else begin
            restart_reg <= restart_next;
            if (restart_next) begin
                active_reg <= adv_view;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lp_reg  <= LP_RESET;
            exp_reg <= EXP_RESET;
        end else begin
            if (i_lp_page.valid) begin
                lp_reg <= i_lp_page.page;
            end
            if (i_an_done.valid) begin
                exp_reg <= {12'h000, i_an_done.lp_np_able, i_an_done.lp_an_able,
                            1'b0, i_an_done.local_an_able};
            end
        end
    end

    // Partner selector decode
    always_comb begin
        case (lp_reg[SEL_MSB:0])
            SEL_IEEE_8023:  o_lp_selector = AAR_SEL_IEEE_8023;
            SEL_ISLAN_16T:  o_lp_selector = AAR_SEL_ISLAN_16T;
            SEL_TOKEN_RING: o_lp_selector = AAR_SEL_TOKEN_RING;
            SEL_IEEE_1394:  o_lp_selector = AAR_SEL_IEEE_1394;
            default:        o_lp_selector = AAR_SEL_RESERVED;
        endcase
    end

    // Read mux; restart self-clears and reads zero, unmapped words read zero
    wire [15:0] sel_stat = {13'h0000, o_lp_selector};
    wire [15:0] rd_mux =
        (dp_index_reg == IDX_ADVERTISEMENT) ? adv_view :
        (dp_index_reg == IDX_LP_BASE)       ? lp_reg :
        (dp_index_reg == IDX_EXPANSION)     ? exp_reg :
        (dp_index_reg == IDX_SELECTOR_STAT) ? sel_stat : 16'h0000;

    assign o_hrdata     = (dp_valid_reg & ~dp_write_reg) ? {16'h0000, rd_mux} : 32'h00000000;
    assign o_hreadyout  = 1'b1;
    assign o_hresp      = 1'b0;
    assign o_adv_active = active_reg;
    assign o_restart    = restart_reg;

    // Helper: no advertisement write since reset
    logic adv_untouched_reg;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            adv_untouched_reg <= 1'b1;
        end else if (wr_adv) begin
            adv_untouched_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    property p_active_frozen;
        !o_restart |-> (o_adv_active == $past(o_adv_active));
    endproperty
    a_active_frozen: assert property (p_active_frozen)
        else $error("Active advertisement changed without restart");

    property p_tech_write;
        wr_adv |=> (tech_reg == $past(i_hwdata[TECH_MSB:TECH_LSB]));
    endproperty
    a_tech_write: assert property (p_tech_write)
        else $error("Technology field did not take written value");

    property p_ten_half_follows;
        restart_next |=> (o_adv_active[TECH_LSB] == $past(tech_reg[0])) && o_restart;
    endproperty
    a_ten_half_follows: assert property (p_ten_half_follows)
        else $error("10BASE-T half ability not carried on restart");

    property p_reset_value;
        adv_untouched_reg |-> (adv_view == ADV_RESET);
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("Advertisement not at reset value before first write");

    property p_selector_fixed;
        ##1 (adv_view[SEL_MSB:0] == SEL_IEEE_8023) && (o_adv_active[SEL_MSB:0] == SEL_IEEE_8023);
    endproperty
    a_selector_fixed: assert property (p_selector_fixed)
        else $error("Local selector not 0x01");

    property p_lp_capture;
        i_lp_page.valid |=> (lp_reg == $past(i_lp_page.page))
            ##1 ($stable(lp_reg) || $past(i_lp_page.valid));
    endproperty
    a_lp_capture: assert property (p_lp_capture)
        else $error("Partner base page not captured");

    property p_selector_decode;
        ((lp_reg[SEL_MSB:0] == SEL_IEEE_1394) == (o_lp_selector == AAR_SEL_IEEE_1394))
            && (((lp_reg[SEL_MSB:0] > SEL_IEEE_1394) || (lp_reg[SEL_MSB:0] == 5'h00))
                == (o_lp_selector == AAR_SEL_RESERVED));
    endproperty
    a_selector_decode: assert property (p_selector_decode)
        else $error("Partner selector decoded wrongly");

    property p_expansion_hold;
        !$past(i_an_done.valid) |-> $stable(exp_reg);
    endproperty
    a_expansion_hold: assert property (p_expansion_hold)
        else $error("Expansion changed without completion");

    property p_next_page_zero;
        ##1 !adv_view[NEXT_PAGE_BIT] && (adv_view[REMOTE_FAULT_BIT] == rf_reg);
    endproperty
    a_next_page_zero: assert property (p_next_page_zero)
        else $error("Next page bit not zero");

    property p_restart_cause;
        o_restart |-> $past(wr_ctrl && i_hwdata[RESTART_BIT]);
    endproperty
    a_restart_cause: assert property (p_restart_cause)
        else $error("Restart pulse without a control write");

    property p_lp_readonly;
        !i_lp_page.valid |=> $stable(lp_reg);
    endproperty
    a_lp_readonly: assert property (p_lp_readonly)
        else $error("Partner base page changed without a received page");

    property p_expansion_fields;
        i_an_done.valid |=> (exp_reg[EXP_LOCAL_AN_BIT] == $past(i_an_done.local_an_able))
            && (exp_reg[EXP_LP_AN_BIT] == $past(i_an_done.lp_an_able))
            && (exp_reg[EXP_LP_NP_BIT] == $past(i_an_done.lp_np_able))
            && !exp_reg[EXP_LOCAL_NP_BIT];
    endproperty
    a_expansion_fields: assert property (p_expansion_fields)
        else $error("Expansion fields not loaded from completion report");

endmodule // aar_regs

/* common/aar_pkg.sv */
// Constants and carrier types for the auto-negotiation ability register slice
package aar_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0]  IDX_BASIC_CONTROL  = 8'h00;
    localparam logic [7:0]  IDX_ADVERTISEMENT  = 8'h04;
    localparam logic [7:0]  IDX_LP_BASE        = 8'h05;
    localparam logic [7:0]  IDX_EXPANSION      = 8'h06;
    localparam logic [7:0]  IDX_SELECTOR_STAT  = 8'h07;

    // Field positions
    localparam int          RESTART_BIT        = 9;
    localparam int          NEXT_PAGE_BIT      = 15;
    localparam int          REMOTE_FAULT_BIT   = 13;
    localparam int          TECH_LSB           = 5;
    localparam int          TECH_MSB           = 8;
    localparam int          SEL_MSB            = 4;
    localparam int          EXP_LOCAL_AN_BIT   = 0;
    localparam int          EXP_LOCAL_NP_BIT   = 1;
    localparam int          EXP_LP_AN_BIT      = 2;
    localparam int          EXP_LP_NP_BIT      = 3;

    // Reset values
    localparam logic [15:0] ADV_RESET          = 16'h01e1;
    localparam logic [3:0]  TECH_RESET         = 4'hf;
    localparam logic [15:0] LP_RESET           = 16'h0000;
    localparam logic [15:0] EXP_RESET          = 16'h0000;

    // Selector codes
    localparam logic [4:0]  SEL_IEEE_8023      = 5'h01;
    localparam logic [4:0]  SEL_ISLAN_16T      = 5'h02;
    localparam logic [4:0]  SEL_TOKEN_RING     = 5'h03;
    localparam logic [4:0]  SEL_IEEE_1394      = 5'h04;

    typedef enum logic [2:0] {
        AAR_SEL_RESERVED,
        AAR_SEL_IEEE_8023,
        AAR_SEL_ISLAN_16T,
        AAR_SEL_TOKEN_RING,
        AAR_SEL_IEEE_1394
    } aar_selector_t;

    // Base page received from the partner, one-cycle valid
    typedef struct packed {
        logic        valid;
        logic [15:0] page;
    } aar_lp_page_t;

    // Capability report at the end of negotiation, one-cycle valid
    typedef struct packed {
        logic        valid;
        logic        local_an_able;
        logic        lp_an_able;
        logic        lp_np_able;
    } aar_an_done_t;

endpackage

/* dv/aar_link_partner.sv */
// Behavioural remote link partner that delivers base pages and completion reports
`timescale 1ns/1ps
module aar_link_partner
    import aar_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic        i_send_page,
    input  wire logic [15:0] i_page,
    input  wire logic        i_send_done,
    input  wire logic [2:0]  i_caps,
    output aar_lp_page_t     o_lp_page,
    output aar_an_done_t     o_an_done
);
    // Data inverts between pulses so a capture outside the valid cycle cannot match by luck
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_lp_page <= '0;
            o_an_done <= '0;
        end else begin
            o_lp_page.valid <= i_send_page;
            o_lp_page.page  <= i_send_page ? i_page : ~o_lp_page.page;
            o_an_done       <= {i_send_done, i_send_done ? i_caps : ~o_an_done[2:0]};
        end
    end
endmodule // aar_link_partner

/* dv/aar_regs_test.sv */
// Register and partner-capture tests for the auto-negotiation register slice
`timescale 1ns/1ps
module aar_regs_test;
    import aar_pkg::*;
    logic          clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd, exp_sel;
    logic          hreadyout, hresp, restart, send_page = 1'b0, send_done = 1'b0;
    logic [15:0]   page = 16'h0, adv;
    logic [2:0]    caps = 3'h0;
    logic [4:0]    codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1f};
    aar_lp_page_t  lp_page;
    aar_an_done_t  an_done;
    aar_selector_t sel;
    int            fail_count = 0, checks = 0;

    always #25 clock = ~clock;

    aar_regs i_aar_regs (.i_clock(clock), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_lp_page(lp_page), .i_an_done(an_done), .o_adv_active(adv), .o_restart(restart),
        .o_lp_selector(sel));
    aar_link_partner i_aar_link_partner (.i_clock(clock), .i_reset_n(reset_n),
        .i_send_page(send_page), .i_page(page), .i_send_done(send_done), .i_caps(caps),
        .o_lp_page(lp_page), .o_an_done(an_done));

    task finish_test;
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait for hready so a stuck slave ends the run instead of hanging it
    task tick;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            finish_test;
        end
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        tick;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        tick;
        rd = hrdata;
    endtask

    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task partner(input logic p, input logic [15:0] v, input logic [2:0] c);
        send_page <= p;
        send_done <= !p;
        page      <= v;
        caps      <= c;
        @(posedge clock);
        send_page <= 1'b0;
        send_done <= 1'b0;
        @(posedge clock);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk({16'h0, adv}, 32'h01e1);
        rdchk(32'h10, 32'h01e1);
        rdchk(32'h14, 32'h0);
        rdchk(32'h18, 32'h0);
        bus(1'b1, 32'h10, 32'hffffffff);
        rdchk(32'h10, 32'h21e1);
        bus(1'b1, 32'h10, 32'h0);
        rdchk(32'h10, 32'h0001);
        bus(1'b1, 32'h10, 32'h0020);
        rdchk(32'h10, 32'h0021);
        chk({16'h0, adv}, 32'h01e1);
        bus(1'b1, 32'h00, 32'h0200);
        #1 chk({31'h0, restart}, 32'h1);
        @(posedge clock);
        @(posedge clock);
        chk({16'h0, adv}, 32'h0021);
        for (int i = 0; i < 7; i++) begin
            partner(1'b1, 16'ha5e0 | {11'h0, codes[i]}, 3'h0);
            rdchk(32'h14, {16'h0, 16'ha5e0 | {11'h0, codes[i]}});
            exp_sel = (codes[i] >= 5'h01 && codes[i] <= 5'h04) ? {27'h0, codes[i]} : 32'h0;
            chk({29'h0, sel}, exp_sel);
            rdchk(32'h1c, exp_sel);
        end
        bus(1'b1, 32'h14, 32'h0);
        rdchk(32'h14, 32'ha5ff);
        partner(1'b0, 16'h0, 3'h7);
        rdchk(32'h18, 32'h000d);
        partner(1'b0, 16'h0, 3'h2);
        bus(1'b1, 32'h18, 32'hffff);
        rdchk(32'h18, 32'h0004);
        rdchk(32'h40, 32'h0);
        rdchk(32'h10, 32'h0021);
        bus(1'b1, 32'h10, rd | 32'h2000);
        rdchk(32'h10, 32'h2021);
        bus(1'b1, 32'h00, 32'h0200);
        @(posedge clock);
        chk({16'h0, adv}, 32'h2021);
        finish_test;
    end
endmodule // aar_regs_test
